// file: gpd_pkg.sv
// package of codes, states and reset values for the gpib command decoder
package gpd_pkg;

  // ------------------------------------------------------------------
  // multiline interface command codes (true logic, seven bits used)
  // ------------------------------------------------------------------
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;

  // ------------------------------------------------------------------
  // address groups: bits 6:5 select the group, bits 4:0 the address
  // ------------------------------------------------------------------
  localparam logic [1:0] GRP_LISTEN    = 2'h1;
  localparam logic [1:0] GRP_TALK      = 2'h2;
  localparam logic [1:0] GRP_SECONDARY = 2'h3;
  localparam int         GRP_LSB       = 5;
  localparam int         ADDR_W        = 5;

  // ------------------------------------------------------------------
  // status byte sent during a serial poll
  // ------------------------------------------------------------------
  localparam int         STB_RQS_BIT   = 6;
  localparam int         STB_USER_W    = 6;

  // ------------------------------------------------------------------
  // synchroniser pin order and idle (reset) levels
  // ------------------------------------------------------------------
  localparam int         PIN_ATN       = 0;
  localparam int         PIN_IFC       = 1;
  localparam int         PIN_REN       = 2;
  localparam int         PIN_LKEY      = 3;
  localparam int         PIN_W         = 4;
  localparam logic [3:0] PIN_RST_VAL   = 4'hf; // every pin idles high

  // ------------------------------------------------------------------
  // remote/local state machine, one-hot
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    RL_LOCAL       = 4'h1,
    RL_REMOTE      = 4'h2,
    RL_REMOTE_LOCK = 4'h4,
    RL_LOCAL_LOCK  = 4'h8
  } gpd_rl_t;

  // talker function, one-hot
  typedef enum logic [1:0] {
    TK_IDLE = 2'h1,
    TK_ADDR = 2'h2
  } gpd_tk_t;

  // reset values of the output flags
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_OE_N = 1'b1;

endpackage : gpd_pkg

// file: gpd_sync.sv
// two flip-flop synchroniser for the asynchronous bus pins
`timescale 1ns/1ps
module gpd_sync
  import gpd_pkg::*;
#(
  parameter int              W       = 4,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // pins in, synchronised levels out
  input  wire logic [W-1:0]  pin_in,
  output logic      [W-1:0]  pin_sync
);

  // ------------------------------------------------------------------
  // one two-stage chain per pin; stage one feeds stage two only
  // ------------------------------------------------------------------
  logic [W-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          stage1[i]   <= RST_VAL[i];
          pin_sync[i] <= RST_VAL[i];
        end else begin
          stage1[i]   <= pin_in[i];
          pin_sync[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule // gpd_sync

// file: gpd_classify.sv
// combinational classifier of one byte received with attention true
`timescale 1ns/1ps
module gpd_classify
  import gpd_pkg::*;
(
  // received byte in bus polarity and own primary address
  input  wire logic [7:0]        dio_n,
  input  wire logic [ADDR_W-1:0] my_addr,
  // one flag per recognised command
  output logic                   is_gtl,
  output logic                   is_sdc,
  output logic                   is_get,
  output logic                   is_llo,
  output logic                   is_dcl,
  output logic                   is_spe,
  output logic                   is_spd,
  output logic                   is_unl,
  output logic                   is_unt,
  output logic                   is_mla,
  output logic                   is_mta,
  output logic                   is_ota
);

  // ------------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------------
  logic [6:0]        code;
  logic [1:0]        grp;
  logic [ADDR_W-1:0] low;
  logic              mine;

  // bus lines are low true; dio8 plays no part in a command
  assign code = ~dio_n[6:0];
  assign grp  = code[6:GRP_LSB];
  assign low  = code[ADDR_W-1:0];
  assign mine = (low == my_addr);

  // fixed command codes
  assign is_gtl = (code == CMD_GTL);
  assign is_sdc = (code == CMD_SDC);
  assign is_get = (code == CMD_GET);
  assign is_llo = (code == CMD_LLO);
  assign is_dcl = (code == CMD_DCL);
  assign is_spe = (code == CMD_SPE);
  assign is_spd = (code == CMD_SPD);
  assign is_unl = (code == CMD_UNL);
  assign is_unt = (code == CMD_UNT);

  // address groups; unlisten and untalk are never taken as addresses,
  // and the secondary group decodes to nothing at all
  assign is_mla = (grp == GRP_LISTEN) && mine && !is_unl;
  assign is_mta = (grp == GRP_TALK) && mine && !is_unt;
  assign is_ota = (grp == GRP_TALK) && !mine && !is_unt;

endmodule // gpd_classify

// file: gpd_decoder.sv
// gpib bus command decoder: interface states, clears, trigger, data path
//
// Behaviour
// - uniline commands are single low-true lines; no data byte used.
// - every byte taken with attention true is a command or address.
// - bytes taken with attention false go to the message output while listening.
// - attention, interface clear and remote enable are inputs only.
// - service request stays asserted until the serial poll handles it.
// - end flag accompanies the last byte in both directions.
// - remote enable plus own listen address moves local to remote.
// - local lockout also disables the local key.
// - interface clear idles talker, listener and serial poll mode.
// - universal commands act whether addressed or not.
// - device clear requests a return to power-up defaults.
// - serial poll enable enters poll mode; disable leaves it.
// - addressed commands act only when addressed to listen.
// - selective clear acts as device clear, only when listening.
// - go-to-local leaves remote; lockout release is configurable.
// - group trigger fires when listening, or always if configured.
// - own listen address is primary address ored with 20 hex.
// - own talk address is primary address ored with 40 hex.
// - secondary command group bytes are ignored.
// - unlisten idles the listener whatever its addressing.
// - untalk idles an addressed talker.
// - command codes are fixed hexadecimal values.
`timescale 1ns/1ps
module gpd_decoder
  import gpd_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // management pins, low true, asynchronous
  input  wire logic                  atn_n,
  input  wire logic                  ifc_n,
  input  wire logic                  ren_n,
  // front panel local key, asynchronous, high when pressed
  input  wire logic                  local_key,
  // byte accepted by the handshake layer, same clock
  input  wire logic                  rx_stb,
  input  wire logic [7:0]            rx_dio_n,
  input  wire logic                  rx_atn_n,
  input  wire logic                  rx_eoi_n,
  // configuration
  input  wire logic [ADDR_W-1:0]     my_addr,
  input  wire logic                  cfg_ren_panel_lock,
  input  wire logic                  cfg_gtl_unlock,
  input  wire logic                  cfg_trig_unaddr,
  // device side: service need, status bits and source bytes
  input  wire logic                  svc_need,
  input  wire logic [STB_USER_W-1:0] status_bits,
  input  wire logic                  tx_stb,
  input  wire logic [7:0]            tx_data,
  input  wire logic                  tx_last,
  // handshake layer ready to take a source byte
  input  wire logic                  src_ready,
  // message input to the command parser
  output logic                       msg_stb,
  output logic [7:0]                 msg_data,
  output logic                       msg_end,
  // source byte to the handshake layer
  output logic                       src_stb,
  output logic [7:0]                 src_data,
  output logic                       src_eoi,
  output logic                       tx_ack,
  // interface state
  output logic                       listen,
  output logic                       talk,
  output logic                       spoll_mode,
  output logic                       remote,
  output logic                       lockout,
  output logic                       local_key_en,
  output logic                       panel_lock,
  // device requests, one-cycle pulses
  output logic                       dev_clear,
  output logic                       trigger,
  // service request pin, open drain
  output logic                       srq_o,
  output logic                       srq_oe_n
);

  // ------------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------------
  logic [PIN_W-1:0] pins_raw, pins_s;
  logic             atn, ifc, ren, lkey, lkey_q, lkey_press;
  // the controller owns these lines; they are only ever sampled here
  assign pins_raw[PIN_ATN]  = atn_n;
  assign pins_raw[PIN_IFC]  = ifc_n;
  assign pins_raw[PIN_REN]  = ren_n;
  assign pins_raw[PIN_LKEY] = ~local_key;

  gpd_sync #(
    .W       (PIN_W),
    .RST_VAL (PIN_RST_VAL)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   (pins_raw),
    .pin_sync (pins_s)
  );

  // low on the wire means true
  assign atn  = ~pins_s[PIN_ATN];
  assign ifc  = ~pins_s[PIN_IFC];
  assign ren  = ~pins_s[PIN_REN];
  assign lkey = ~pins_s[PIN_LKEY];

  // key edge, so a held key acts once
  assign lkey_press = lkey && !lkey_q;

  // ------------------------------------------------------------------
  // byte classification
  // ------------------------------------------------------------------
  logic is_gtl, is_sdc, is_get, is_llo, is_dcl, is_spe;
  logic is_spd, is_unl, is_unt, is_mla, is_mta, is_ota;
  gpd_classify u_classify (
    .dio_n   (rx_dio_n),
    .my_addr (my_addr),
    .is_gtl  (is_gtl),
    .is_sdc  (is_sdc),
    .is_get  (is_get),
    .is_llo  (is_llo),
    .is_dcl  (is_dcl),
    .is_spe  (is_spe),
    .is_spd  (is_spd),
    .is_unl  (is_unl),
    .is_unt  (is_unt),
    .is_mla  (is_mla),
    .is_mta  (is_mta),
    .is_ota  (is_ota)
  );

  // ------------------------------------------------------------------
  // command and data qualification
  // ------------------------------------------------------------------
  logic cmd, dat, cmd_live, addr_cmd;
  // attention travels with the byte from the handshake layer, so a
  // late edge on the synchronised pin cannot misfile a byte
  assign cmd      = rx_stb && !rx_atn_n;
  assign dat      = rx_stb && rx_atn_n;
  // nothing is decoded while interface clear holds the bus
  assign cmd_live = cmd && !ifc;
  // addressed commands need a prior own listen address
  assign addr_cmd = cmd_live && listen;

  // ------------------------------------------------------------------
  // listener and talker
  // ------------------------------------------------------------------
  logic    next_listen;
  gpd_tk_t tk_state, next_tk;
  // secondary group bytes match none of these terms and change nothing
  assign next_listen =
    ifc                   ? 1'b0 :
    (cmd_live && is_unl)  ? 1'b0 :
    (cmd_live && is_mla)  ? 1'b1 :
    (cmd_live && is_mta)  ? 1'b0 :
                            listen;

  always_comb begin
    next_tk = tk_state;
    if (ifc) begin
      next_tk = TK_IDLE;
    end else if (cmd_live) begin
      if (is_unt || is_ota) begin
        next_tk = TK_IDLE;
      end else if (is_mta) begin
        next_tk = TK_ADDR;
      end else if (is_mla) begin
        next_tk = TK_IDLE;
      end
    end
  end

  // ------------------------------------------------------------------
  // serial poll mode
  // ------------------------------------------------------------------
  logic next_spoll;
  assign next_spoll =
    ifc                   ? 1'b0 :
    (cmd_live && is_spe)  ? 1'b1 :
    (cmd_live && is_spd)  ? 1'b0 :
                            spoll_mode;

  // ------------------------------------------------------------------
  // remote/local machine
  // ------------------------------------------------------------------
  gpd_rl_t rl_state, next_rl;
  logic    gtl_hit, llo_hit, mla_hit;
  assign gtl_hit = addr_cmd && is_gtl;
  assign llo_hit = cmd_live && is_llo;
  assign mla_hit = cmd_live && is_mla;

  // dropping remote enable always returns to plain local
  always_comb begin
    next_rl = rl_state;
    if (!ren) begin
      next_rl = RL_LOCAL;
    end else begin
      case (rl_state)
        RL_LOCAL: begin
          if (llo_hit) begin
            next_rl = RL_LOCAL_LOCK;
          end else if (mla_hit) begin
            next_rl = RL_REMOTE;
          end
        end
        RL_REMOTE: begin
          if (llo_hit) begin
            next_rl = RL_REMOTE_LOCK;
          end else if (gtl_hit || lkey_press) begin
            next_rl = RL_LOCAL;
          end
        end
        RL_REMOTE_LOCK: begin
          // the local key has no effect here
          if (gtl_hit) begin
            next_rl = cfg_gtl_unlock ? RL_LOCAL
                                     : RL_LOCAL_LOCK;
          end
        end
        RL_LOCAL_LOCK: begin
          if (mla_hit) begin
            next_rl = RL_REMOTE_LOCK;
          end
        end
        default: begin
          next_rl = RL_LOCAL;
        end
      endcase
    end
  end

  logic next_remote, next_lockout;
  assign next_remote  = (next_rl == RL_REMOTE) ||
                        (next_rl == RL_REMOTE_LOCK);
  assign next_lockout = (next_rl == RL_REMOTE_LOCK) ||
                        (next_rl == RL_LOCAL_LOCK);

  // ------------------------------------------------------------------
  // device clear and trigger requests
  // ------------------------------------------------------------------
  logic next_clear, next_trig;
  assign next_clear = (cmd_live && is_dcl) ||
                      (addr_cmd && is_sdc);
  assign next_trig  = cmd_live && is_get &&
                      (listen || cfg_trig_unaddr);

  // ------------------------------------------------------------------
  // service request and serial poll answer
  // ------------------------------------------------------------------
  logic       srq_pend, svc_q, poll_sent;
  logic       talk_ok, poll_go, next_pend, next_sent;
  logic [7:0] stb_byte;
  // the talker sends only while attention is false
  assign talk_ok  = talk && !atn && src_ready;
  assign poll_go  = talk_ok && spoll_mode && !poll_sent;
  assign stb_byte = {1'b0, srq_pend, status_bits};

  // a new need that lands on the poll cycle survives it
  assign next_pend = (svc_need && !svc_q) ? 1'b1 :
                     poll_go              ? 1'b0 :
                                            srq_pend;
  // one status byte per poll; rearmed when attention returns
  assign next_sent = atn     ? 1'b0 :
                     poll_go ? 1'b1 :
                               poll_sent;

  // ------------------------------------------------------------------
  // source data path
  // ------------------------------------------------------------------
  logic tx_take;
  // device bytes are held off during a serial poll
  assign tx_take = tx_stb && talk_ok && !spoll_mode;

  // ------------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rl_state   <= RL_LOCAL;
      tk_state   <= TK_IDLE;
      listen     <= RST_FLAG;
      talk       <= RST_FLAG;
      spoll_mode <= RST_FLAG;
      remote     <= RST_FLAG;
      lockout    <= RST_FLAG;
      dev_clear  <= RST_FLAG;
      trigger    <= RST_FLAG;
    end else begin
      rl_state   <= next_rl;
      tk_state   <= next_tk;
      listen     <= next_listen;
      talk       <= (next_tk == TK_ADDR);
      spoll_mode <= next_spoll;
      remote     <= next_remote;
      lockout    <= next_lockout;
      dev_clear  <= next_clear;
      trigger    <= next_trig;
    end
  end

  // panel and key enables follow the remote/local state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      local_key_en <= 1'b1;
      panel_lock   <= RST_FLAG;
      lkey_q       <= RST_FLAG;
    end else begin
      local_key_en <= !next_lockout;
      panel_lock   <= next_remote &&
                      (cfg_ren_panel_lock || next_lockout);
      lkey_q       <= lkey;
    end
  end

  // message input; only a listener takes device data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      msg_stb  <= RST_FLAG;
      msg_data <= 8'h00;
      msg_end  <= RST_FLAG;
    end else begin
      msg_stb  <= dat && listen && !ifc;
      msg_data <= ~rx_dio_n;
      msg_end  <= !rx_eoi_n;
    end
  end

  // source bytes; the poll answer outranks device data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_stb  <= RST_FLAG;
      src_data <= 8'h00;
      src_eoi  <= RST_FLAG;
      tx_ack   <= RST_FLAG;
    end else begin
      src_stb  <= poll_go || tx_take;
      src_data <= poll_go ? stb_byte : tx_data;
      src_eoi  <= !poll_go && tx_take && tx_last;
      tx_ack   <= tx_take;
    end
  end

  // service request pin: drive low only while a request is pending
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      srq_pend  <= RST_FLAG;
      svc_q     <= RST_FLAG;
      poll_sent <= RST_FLAG;
      srq_o     <= RST_FLAG;
      srq_oe_n  <= RST_OE_N;
    end else begin
      srq_pend  <= next_pend;
      svc_q     <= svc_need;
      poll_sent <= next_sent;
      srq_o     <= 1'b0;
      srq_oe_n  <= !next_pend;
    end
  end

endmodule // gpd_decoder

// file: gpd_ctrl.sv
// bus controller model: management pins and the bytes it hands over
`timescale 1ns/1ps
module gpd_ctrl (
  // clock
  input  wire logic       sys_clk,
  // management pins, low true; the device only reads them
  output logic            atn_n,
  output logic            ifc_n,
  output logic            ren_n,
  // byte as accepted by the handshake layer
  output logic            rx_stb,
  output logic      [7:0] rx_dio_n,
  output logic            rx_atn_n,
  output logic            rx_eoi_n
);
  // nothing asserted at time zero
  initial {atn_n, ifc_n, ren_n, rx_stb} = 4'he;
  initial {rx_dio_n, rx_atn_n, rx_eoi_n} = 10'h3ff;
  // uniline command: asserting a line pulls it low
  task pins(input logic atn, input logic ifc, input logic ren);
    @(posedge sys_clk);
    {atn_n, ifc_n, ren_n} <= ~{atn, ifc, ren};
  endtask
  // one byte; attention marks a command, e the last data byte
  task send(input logic a, input logic [7:0] b, input logic e);
    @(posedge sys_clk);
    {rx_stb, rx_dio_n, rx_atn_n, rx_eoi_n} <= {1'b1, ~b, ~a, ~e};
    @(posedge sys_clk);
    rx_stb   <= 1'b0;
    rx_dio_n <= 8'hff; // released lines float high on their pull-ups
  endtask
endmodule // gpd_ctrl

// file: gpd_decoder_assertions.sv
// checker of the command decoder port relations
`timescale 1ns/1ps
module gpd_chk
  import gpd_pkg::*;
(
  // clock, reset and bus side inputs
  input wire logic              sys_clk, rst, ifc_n, rx_stb, rx_atn_n,
  input wire logic [7:0]        rx_dio_n,
  input wire logic [ADDR_W-1:0] my_addr,
  // watched outputs
  input wire logic              msg_stb, listen, talk, spoll_mode, dev_clear,
  input wire logic [7:0]        msg_data
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  // bytes count only once ifc has been idle through the synchroniser
  logic [3:0] ifc_h;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) ifc_h <= 4'h0;
    else ifc_h <= {ifc_h[2:0], ifc_n};
  wire       cmd = rx_stb && !rx_atn_n && (&ifc_h);
  wire [6:0] cb  = ~rx_dio_n[6:0]; // bit 8 plays no part in commands
  wire       mla = cmd && cb == {GRP_LISTEN, my_addr};
  wire       mta = cmd && cb == {GRP_TALK, my_addr};
  AST_MLA: assert property (mla |=> listen && !talk)
    else $error("own listen address not taken");
  AST_MTA: assert property (mta |=> talk && !listen)
    else $error("own talk address not taken");
  AST_UNL: assert property (cmd && cb == CMD_UNL |=> !listen)
    else $error("unlisten ignored");
  AST_UNT: assert property (cmd && cb == CMD_UNT |=> !talk)
    else $error("untalk ignored");
  AST_SDC: assert property (cmd && cb == CMD_SDC && listen |=> dev_clear)
    else $error("selective clear lost");
  AST_DCL: assert property (cmd && cb == CMD_DCL |=> dev_clear)
    else $error("device clear lost");
  AST_SPE: assert property (cmd && cb == CMD_SPE |=> spoll_mode)
    else $error("poll mode not entered");
  AST_IFC: assert property (!ifc_n [*4] |=> !listen && !talk && !spoll_mode)
    else $error("interface clear not obeyed");
  AST_DATA: assert property (rx_stb && rx_atn_n && listen && (&ifc_h)
    |=> msg_stb && msg_data == ~$past(rx_dio_n))
    else $error("data byte not passed on");
  cover property (mla);
  cover property (dev_clear);
  cover property (spoll_mode && talk);
endmodule // gpd_chk
bind gpd_decoder gpd_chk u_gpd_chk (.sys_clk, .rst, .ifc_n, .rx_stb,
  .rx_atn_n, .rx_dio_n, .my_addr, .msg_stb, .listen, .talk, .spoll_mode,
  .dev_clear, .msg_data);

// file: gpd_decoder_bench.sv
// self-checking bench of the gpib command decoder
`timescale 1ns/1ps
module gpd_decoder_bench
  import gpd_pkg::*;
;
  logic       sys_clk = 1'b0, rst = 1'b1, local_key = 1'b0, svc_need = 1'b0;
  logic       tx_stb = 1'b0, tx_last = 1'b0, src_ready = 1'b0;
  logic [7:0] tx_data = 8'h00, rx_dio_n, msg_data, src_data;
  logic       atn_n, ifc_n, ren_n, rx_stb, rx_atn_n, rx_eoi_n, msg_stb;
  logic       msg_end, src_stb, src_eoi, tx_ack, listen, talk, spoll_mode;
  logic       remote, lockout, local_key_en, panel_lock, dev_clear, trigger;
  logic       srq_o, srq_oe_n, cfg_trig_unaddr = 1'b0;
  int         n_errors = 0, checked = 0;
  localparam logic [7:0] MLA = 8'h3b, MTA = 8'h5b; // address 27
  always #50 sys_clk = ~sys_clk;
  gpd_ctrl u_gpd_ctrl (.sys_clk, .atn_n, .ifc_n, .ren_n, .rx_stb, .rx_dio_n,
    .rx_atn_n, .rx_eoi_n);
  gpd_decoder u_gpd_decoder (.sys_clk, .rst, .atn_n, .ifc_n, .ren_n,
    .local_key, .rx_stb, .rx_dio_n, .rx_atn_n, .rx_eoi_n, .my_addr(5'h1b),
    .cfg_ren_panel_lock(1'b0), .cfg_gtl_unlock(1'b1), .cfg_trig_unaddr,
    .svc_need, .status_bits(6'h2d), .tx_stb, .tx_data, .tx_last, .src_ready,
    .msg_stb, .msg_data, .msg_end, .src_stb, .src_data, .src_eoi, .tx_ack,
    .listen, .talk, .spoll_mode, .remote, .lockout, .local_key_en,
    .panel_lock, .dev_clear, .trigger, .srq_o, .srq_oe_n);
  task results;
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // command byte, then let the answering edge settle before looking
  task cmd(input logic [7:0] b);
    u_gpd_ctrl.send(1'b1, b, 1'b0);
    #1;
  endtask
  // bounded wait for a source byte; a hang ends the run
  task wsrc;
    for (int k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      #1;
      if (src_stb === 1'b1) return;
    end
    chk(1'b0, "no source byte");
    results();
  endtask
  task t_listen;
    cmd({1'b0, CMD_UNL});
    cmd(MLA);
    chk({listen, remote} === 2'b11, "mla");
    cmd({1'b0, CMD_SDC});
    chk(dev_clear === 1'b1, "sdc");
    cmd({1'b0, CMD_GET});
    chk(trigger === 1'b1, "get");
    u_gpd_ctrl.send(1'b0, 8'h2a, 1'b1);
    #1;
    chk({msg_stb, msg_end, msg_data} === 10'h32a, "data");
    cmd({1'b0, CMD_UNL});
    chk(listen === 1'b0, "unl");
    cmd({1'b0, CMD_GET});
    chk(trigger === 1'b0, "get unaddressed");
    @(posedge sys_clk) cfg_trig_unaddr <= 1'b1;
    cmd({1'b0, CMD_GET});
    chk(trigger === 1'b1, "get unaddressed enabled");
    cmd({1'b0, CMD_SDC});
    chk(dev_clear === 1'b0, "sdc unaddressed");
    cmd({1'b0, CMD_DCL});
    chk(dev_clear === 1'b1, "dcl");
  endtask
  task t_lock;
    cmd(MLA);
    cmd({1'b0, CMD_LLO});
    chk({lockout, local_key_en, panel_lock} === 3'b101, "llo");
    @(posedge sys_clk) local_key <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(remote === 1'b1, "key in lockout");
    cmd({1'b0, CMD_GTL});
    chk({remote, lockout} === 2'b00, "gtl");
    cmd(8'h7b);
    chk(listen === 1'b1, "secondary");
    u_gpd_ctrl.pins(1'b1, 1'b1, 1'b1);
    repeat (5) @(posedge sys_clk);
    cmd(MLA);
    chk({listen, talk, spoll_mode} === 3'b000, "ifc");
    u_gpd_ctrl.pins(1'b1, 1'b0, 1'b1);
  endtask
  task t_talk;
    // let interface clear age out of the checker's window first
    repeat (3) @(posedge sys_clk);
    svc_need <= 1'b1;
    cmd({1'b0, CMD_SPE});
    chk({spoll_mode, srq_oe_n, srq_o} === 3'b100, "spe");
    cmd(MTA);
    chk({talk, listen} === 2'b10, "mta");
    u_gpd_ctrl.pins(1'b0, 1'b0, 1'b1);
    src_ready <= 1'b1;
    wsrc();
    chk({src_eoi, src_data} === 9'h06d, "status byte");
    @(posedge sys_clk) src_ready <= 1'b0;
    #1;
    chk(srq_oe_n === 1'b1, "srq release");
    u_gpd_ctrl.pins(1'b1, 1'b0, 1'b1);
    cmd({1'b0, CMD_SPD});
    chk(spoll_mode === 1'b0, "spd");
    u_gpd_ctrl.pins(1'b0, 1'b0, 1'b1);
    {tx_stb, tx_last, src_ready, tx_data} <= {3'h7, 8'hc3};
    wsrc();
    chk({tx_ack, src_eoi, src_data} === 10'h3c3, "tx byte");
    @(posedge sys_clk) {tx_stb, src_ready} <= 2'b00;
    u_gpd_ctrl.pins(1'b1, 1'b0, 1'b1);
    cmd({1'b0, CMD_UNT});
    chk(talk === 1'b0, "unt");
  endtask
  // reset for four cycles, remote enable on, then the scenarios
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    u_gpd_ctrl.pins(1'b1, 1'b0, 1'b1);
    repeat (4) @(posedge sys_clk);
    t_listen();
    t_lock();
    t_talk();
    results();
  end
endmodule // gpd_decoder_bench
